// File: design/psif_pkg.sv
// Constants and types of the PSI5 initialization and error frame generator.
package psif_pkg;
    // Register indexes on the plain register port.
    localparam logic [3:0] ADDR_IDENT_LAST = 4'h7;
    localparam logic [3:0] ADDR_CFG_OUTPUT = 4'h8;
    localparam logic [3:0] ADDR_CFG_PROTOCOL = 4'h9;
    localparam logic [3:0] ADDR_CFG_PROTOCOL2 = 4'hA;
    localparam logic [3:0] ADDR_SEQ_STATUS = 4'hB;
    // Field positions.
    localparam int unsigned K_LSB = 4;
    localparam int unsigned PSIZE_LSB = 0;
    localparam int unsigned REP_LSB = 9;
    localparam int unsigned SEQ_LSB = 3;
    localparam int unsigned LOWSEL_BIT = 0;
    localparam int unsigned ST_LSB = 12;
    localparam int unsigned REPCNT_LSB = 10;
    // Values after reset. The ident value is arbitrary.
    localparam logic [15:0] IDENT_RST = 16'h0000;
    localparam logic [1:0] K_RST = 2'h0;
    localparam logic [3:0] PSIZE_RST = 4'h1;
    localparam logic [6:0] REP_RST = 7'h00;
    localparam logic [1:0] SEQ_RST = 2'h0;
    localparam logic LOWSEL_RST = 1'b0;
    // Message codes, payload sizes and phase II nibble indexes.
    localparam logic [9:0] MSG_READY = 10'h1E7;
    localparam logic [9:0] MSG_DEFECT = 10'h1F4;
    localparam logic [4:0] PSIZE_BASE = 5'h09;
    localparam logic [4:0] BITS_TEN = 5'h0A;
    localparam logic [4:0] BITS_SIXTEEN = 5'h10;
    localparam logic [3:0] PSIZE_F10 = 4'h1;
    localparam logic [3:0] PSIZE_F11 = 4'h2;
    localparam logic [3:0] PSIZE_F16 = 4'h7;
    localparam logic [4:0] NIB_LAST = 5'h1F;
    localparam logic [4:0] NIB_GENERIC = 5'h0C;
    // Sequence select codes.
    localparam logic [1:0] SEQ_AFTER_PH1 = 2'h0;
    localparam logic [1:0] SEQ_AFTER_PH2 = 2'h1;
    localparam logic [1:0] SEQ_AFTER_PH3 = 2'h2;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_PH2 = 4'h2,
        ST_PH3 = 4'h4,
        ST_APP = 4'h8
    } psif_state_t;

    typedef enum logic [1:0] {
        FK_PH2 = 2'h0,
        FK_PH3 = 2'h1,
        FK_ERR = 2'h2,
        FK_APP = 2'h3
    } psif_kind_t;

    typedef struct packed {
        logic over_temp;
        logic under_volt;
        logic over_volt;
        logic magnet_lost;
        logic clipping;
        logic mem_error;
    } psif_diag_t;

    typedef struct packed {
        psif_kind_t kind;
        logic status_flag;
        logic parity_sel;
        logic [4:0] nibble_id;
        logic [23:0] payload;
    } psif_frame_t;
endpackage

// File: design/psif_framer.sv
// Frame content generator for PSI5 init phases II and III and error frames.
//
// Chosen here: the address map and strobed register access.
`timescale 1ns/1ns
module psif_framer
    import psif_pkg::*;
(
    input wire logic I_CORE_CLK,
    input wire logic I_RST,
    input wire logic [3:0] I_ADDR,
    input wire logic [15:0] I_WDATA,
    input wire logic I_WR,
    input wire logic I_RD,
    output logic [15:0] O_RDATA,
    input wire logic I_INIT_START,
    input wire logic I_FRAME_REQ,
    input wire logic I_ERROR_REPORT,
    input wire psif_diag_t I_DIAG,
    input wire logic [23:0] I_APP_DATA,
    output logic O_FRAME_VLD,
    output psif_frame_t O_FRAME
);
    default clocking cb @(posedge I_CORE_CLK);
    endclocking
    default disable iff (I_RST);

    logic [15:0] ident_q [8];
    logic [1:0] k_q;
    logic [3:0] psize_q;
    logic [6:0] rep_field_q;
    logic [1:0] seq_sel_q;
    logic low_sel_q;
    logic [15:0] rdata_q;
    logic [15:0] rdata_d;
    psif_state_t state_q;
    logic [4:0] nib_q;
    logic [1:0] rep_q;
    logic [7:0] p3cnt_q;
    logic [7:0] p3_last;
    logic [3:0] nib_val;
    logic defect;
    logic take_req;
    logic vld_q;
    psif_frame_t frame_q;
    psif_frame_t frame_d;

    // Defect code in the top ten data bits, flags right below it.
    function automatic logic [23:0] err_word(input logic [3:0] f, input psif_diag_t d);
        logic [4:0] p;
        logic [23:0] code;
        logic [23:0] flags;
        p = {1'b0, f} + PSIZE_BASE;
        code = {14'h0000, MSG_DEFECT};
        flags = {18'h00000, d};
        if (p <= BITS_TEN) begin
            return code;
        end
        code = code << (p - BITS_TEN);
        if (p >= BITS_SIXTEEN) begin
            flags = flags << (p - BITS_SIXTEEN);
        end else begin
            flags = flags >> (BITS_SIXTEEN - p);
        end
        return code | flags;
    endfunction

    for (genvar gi = 0; gi < 8; gi++) begin : g_ident
        always_ff @(posedge I_CORE_CLK) begin
            if (I_RST) begin
                ident_q[gi] <= IDENT_RST;
            end else if (I_WR && I_ADDR == 4'(gi)) begin
                ident_q[gi] <= I_WDATA;
            end
        end
    end

    always_ff @(posedge I_CORE_CLK) begin
        if (I_RST) begin
            k_q <= K_RST;
            psize_q <= PSIZE_RST;
            rep_field_q <= REP_RST;
            seq_sel_q <= SEQ_RST;
            low_sel_q <= LOWSEL_RST;
        end else if (I_WR) begin
            if (I_ADDR == ADDR_CFG_OUTPUT) begin
                k_q <= I_WDATA[K_LSB +: 2];
                psize_q <= I_WDATA[PSIZE_LSB +: 4];
            end
            if (I_ADDR == ADDR_CFG_PROTOCOL) begin
                rep_field_q <= I_WDATA[REP_LSB +: 7];
                seq_sel_q <= I_WDATA[SEQ_LSB +: 2];
            end
            if (I_ADDR == ADDR_CFG_PROTOCOL2) begin
                low_sel_q <= I_WDATA[LOWSEL_BIT];
            end
        end
    end

    always_comb begin
        rdata_d = 16'h0000;
        if (I_ADDR <= ADDR_IDENT_LAST) begin
            rdata_d = ident_q[I_ADDR[2:0]];
        end else if (I_ADDR == ADDR_CFG_OUTPUT) begin
            rdata_d[K_LSB +: 2] = k_q;
            rdata_d[PSIZE_LSB +: 4] = psize_q;
        end else if (I_ADDR == ADDR_CFG_PROTOCOL) begin
            rdata_d[REP_LSB +: 7] = rep_field_q;
            rdata_d[SEQ_LSB +: 2] = seq_sel_q;
        end else if (I_ADDR == ADDR_CFG_PROTOCOL2) begin
            rdata_d[LOWSEL_BIT] = low_sel_q;
        end else if (I_ADDR == ADDR_SEQ_STATUS) begin
            rdata_d[ST_LSB +: 4] = state_q;
            rdata_d[REPCNT_LSB +: 2] = rep_q;
            rdata_d[4:0] = nib_q;
        end
    end

    // Read data stand only in the cycle after the strobe.
    always_ff @(posedge I_CORE_CLK) begin
        if (I_RST) begin
            rdata_q <= 16'h0000;
        end else begin
            rdata_q <= I_RD ? rdata_d : 16'h0000;
        end
    end

    assign p3_last = {rep_field_q, 1'b1};
    assign take_req = I_FRAME_REQ && !I_INIT_START && state_q != ST_IDLE;
    assign defect = |I_DIAG;

    // A new start restarts the sequence from any state, as after an undervoltage.
    always_ff @(posedge I_CORE_CLK) begin
        if (I_RST) begin
            state_q <= ST_IDLE;
            nib_q <= 5'h00;
            rep_q <= 2'h0;
            p3cnt_q <= 8'h00;
        end else if (I_INIT_START) begin
            nib_q <= 5'h00;
            rep_q <= 2'h0;
            p3cnt_q <= 8'h00;
            if (seq_sel_q == SEQ_AFTER_PH2 || seq_sel_q == SEQ_AFTER_PH3) begin
                state_q <= ST_PH2;
            end else begin
                state_q <= ST_APP;
            end
        end else if (I_FRAME_REQ) begin
            unique case (state_q)
                ST_PH2: begin
                    if (rep_q == k_q) begin
                        rep_q <= 2'h0;
                        if (nib_q == NIB_LAST) begin
                            nib_q <= 5'h00;
                            state_q <= (seq_sel_q == SEQ_AFTER_PH3) ? ST_PH3 : ST_APP;
                        end else begin
                            nib_q <= nib_q + 5'h01;
                        end
                    end else begin
                        rep_q <= rep_q + 2'h1;
                    end
                end
                ST_PH3: begin
                    if (p3cnt_q == p3_last) begin
                        state_q <= ST_APP;
                    end else begin
                        p3cnt_q <= p3cnt_q + 8'h01;
                    end
                end
                default: begin
                end
            endcase
        end
    end

    logic [4:0] gj;
    always_comb begin
        nib_val = 4'h0;
        gj = nib_q - NIB_GENERIC;
        if (nib_q >= NIB_GENERIC) begin
            nib_val = ident_q[3'h4 - gj[4:2]][{~gj[1:0], 2'b00} +: 4];
        end else begin
            unique case (nib_q)
                5'h00: nib_val = ident_q[7][15:12];
                5'h01: nib_val = ident_q[7][11:8];
                5'h02: nib_val = ident_q[7][7:4];
                5'h03: nib_val = ident_q[7][3:0];
                5'h04: nib_val = ident_q[6][15:12];
                5'h05: nib_val = ident_q[6][7:4];
                5'h06: nib_val = ident_q[6][11:8];
                5'h07: nib_val = ident_q[6][3:0];
                5'h08: nib_val = ident_q[5][15:12];
                5'h09: nib_val = ident_q[5][11:8];
                5'h0A: nib_val = ident_q[5][7:4];
                5'h0B: nib_val = ident_q[5][3:0];
                default: nib_val = 4'h0;
            endcase
        end
    end

    always_comb begin
        frame_d = '0;
        frame_d.parity_sel = (psize_q <= PSIZE_F10);
        frame_d.nibble_id = nib_q;
        unique case (state_q)
            ST_PH2: begin
                frame_d.kind = FK_PH2;
                frame_d.status_flag = 1'b0;
                frame_d.payload = {20'h00000, nib_val};
            end
            ST_PH3: begin
                frame_d.kind = FK_PH3;
                frame_d.status_flag = defect;
                if (defect) begin
                    frame_d.payload[15:6] = MSG_DEFECT;
                    frame_d.payload[5:0] = low_sel_q ? I_DIAG : 6'h00;
                end else begin
                    frame_d.payload[15:6] = MSG_READY;
                    frame_d.payload[5:0] = low_sel_q ? 6'h00 : 6'h01;
                end
            end
            ST_APP: begin
                if (I_ERROR_REPORT) begin
                    frame_d.kind = FK_ERR;
                    frame_d.status_flag = 1'b1;
                    frame_d.payload = err_word(psize_q, I_DIAG);
                end else begin
                    frame_d.kind = FK_APP;
                    frame_d.payload = I_APP_DATA;
                end
            end
            default: begin
            end
        endcase
    end

    // Phase I frames carry no data, so requests in idle get no answer.
    always_ff @(posedge I_CORE_CLK) begin
        if (I_RST) begin
            vld_q <= 1'b0;
            frame_q <= '0;
        end else begin
            vld_q <= take_req;
            if (take_req) begin
                frame_q <= frame_d;
            end
        end
    end

    assign O_RDATA = rdata_q;
    assign O_FRAME_VLD = vld_q;
    assign O_FRAME = frame_q;

    a_ph2_status_zero: assert property (
        O_FRAME_VLD && O_FRAME.kind == FK_PH2 |-> !O_FRAME.status_flag
    ) else $error("phase II frame with status flag set");

    a_err_status_one: assert property (
        O_FRAME_VLD && O_FRAME.kind == FK_ERR |-> O_FRAME.status_flag
    ) else $error("error frame without status flag");

    a_ph3_upper_zero: assert property (
        O_FRAME_VLD && O_FRAME.kind == FK_PH3 |-> O_FRAME.payload[23:16] == 8'h00
    ) else $error("phase III upper bits not zero");

    a_ph3_flag_code: assert property (
        O_FRAME_VLD && O_FRAME.kind == FK_PH3
        |-> O_FRAME.status_flag == (O_FRAME.payload[15:6] == MSG_DEFECT)
    ) else $error("phase III flag does not match message");

    a_req_answer: assert property (
        take_req |=> O_FRAME_VLD ##1 !O_FRAME_VLD || $past(take_req)
    ) else $error("frame request not answered in one cycle");

    a_nib_hold: assert property (
        I_FRAME_REQ && !I_INIT_START && state_q == ST_PH2 && rep_q != k_q
        |=> nib_q == $past(nib_q)
    ) else $error("nibble advanced before its repeats");

    a_ph3_exit: assert property (
        $fell(state_q == ST_PH3) && !$past(I_INIT_START)
        |-> $past(p3cnt_q) == {$past(rep_field_q), 1'b1}
    ) else $error("phase III left after wrong count");

    a_short_code: assert property (
        take_req && state_q == ST_APP && I_ERROR_REPORT && psize_q == PSIZE_F10
        |=> O_FRAME.payload == {14'h0000, MSG_DEFECT}
    ) else $error("ten bit error frame not the defect code");

    a_diag_sixteen: assert property (
        take_req && state_q == ST_APP && I_ERROR_REPORT && psize_q == PSIZE_F16
        |=> O_FRAME.payload[5:0] == $past(I_DIAG) && O_FRAME.payload[15:6] == MSG_DEFECT
    ) else $error("sixteen bit diagnosis placement wrong");

    a_diag_eleven: assert property (
        take_req && state_q == ST_APP && I_ERROR_REPORT && psize_q == PSIZE_F11
        |=> O_FRAME.payload[0] == $past(I_DIAG.over_temp)
            && O_FRAME.payload[10:1] == MSG_DEFECT
    ) else $error("eleven bit diagnosis placement wrong");

    a_seq_skip: assert property (
        I_INIT_START && seq_sel_q == SEQ_AFTER_PH1 |=> state_q == ST_APP
    ) else $error("init not skipped for phase I only");

    a_seq_ph2: assert property (
        I_INIT_START && (seq_sel_q == SEQ_AFTER_PH2 || seq_sel_q == SEQ_AFTER_PH3)
        |=> state_q == ST_PH2
    ) else $error("init did not enter phase II");

    // Content is built from settings at the request edge, so look one cycle back.
    a_ready_low_bits: assert property (
        O_FRAME_VLD && O_FRAME.kind == FK_PH3 && !O_FRAME.status_flag
        |-> O_FRAME.payload[15:6] == MSG_READY
            && O_FRAME.payload[5:0] == ($past(low_sel_q) ? 6'h00 : 6'h01)
    ) else $error("ready message content wrong");

    a_defect_low_bits: assert property (
        O_FRAME_VLD && O_FRAME.kind == FK_PH3 && O_FRAME.status_flag
        |-> O_FRAME.payload[15:6] == MSG_DEFECT
            && O_FRAME.payload[5:0] == ($past(low_sel_q) ? 6'($past(I_DIAG)) : 6'h00)
    ) else $error("defect message content wrong");

    a_parity_select: assert property (
        O_FRAME_VLD |-> O_FRAME.parity_sel == ($past(psize_q) <= PSIZE_F10)
    ) else $error("parity select does not follow payload size");

    a_type_nibble: assert property (
        O_FRAME_VLD && O_FRAME.kind == FK_PH2 && O_FRAME.nibble_id == 5'h05
        |-> O_FRAME.payload[3:0] == $past(ident_q[6][7:4])
    ) else $error("sensor type nibble from wrong bits");

    a_vehicle_nibble: assert property (
        O_FRAME_VLD && O_FRAME.kind == FK_PH2 && O_FRAME.nibble_id == 5'h0B
        |-> O_FRAME.payload[3:0] == $past(ident_q[5][3:0])
    ) else $error("vehicle code nibble from wrong bits");

    a_last_nibble: assert property (
        O_FRAME_VLD && O_FRAME.kind == FK_PH2 && O_FRAME.nibble_id == NIB_LAST
        |-> O_FRAME.payload[3:0] == $past(ident_q[0][3:0])
    ) else $error("last identity nibble from wrong bits");

    a_nib_step: assert property (
        I_FRAME_REQ && !I_INIT_START && state_q == ST_PH2 && rep_q == k_q && nib_q != NIB_LAST
        |=> nib_q == $past(nib_q) + 5'h01 && rep_q == 2'h0
    ) else $error("nibble did not advance after its repeats");

    a_ph3_step: assert property (
        I_FRAME_REQ && !I_INIT_START && state_q == ST_PH3 && p3cnt_q != p3_last
        |=> state_q == ST_PH3 && p3cnt_q == $past(p3cnt_q) + 8'h01
    ) else $error("phase III repeat count did not step");

    a_err_wide: assert property (
        take_req && state_q == ST_APP && I_ERROR_REPORT && psize_q == 4'hF
        |=> O_FRAME.payload == {MSG_DEFECT, $past(I_DIAG), 8'h00}
    ) else $error("wide error frame placement wrong");

    c_ph2_to_ph3: cover property ($rose(state_q == ST_PH3));
    c_err_sixteen: cover property (O_FRAME_VLD && O_FRAME.kind == FK_ERR && psize_q == PSIZE_F16);
    c_ph3_defect: cover property (O_FRAME_VLD && O_FRAME.kind == FK_PH3 && O_FRAME.status_flag);
    c_app_frame: cover property (O_FRAME_VLD && O_FRAME.kind == FK_APP);
    c_ph3_diag: cover property (O_FRAME_VLD && O_FRAME.kind == FK_PH3 && O_FRAME.status_flag
        && low_sel_q);
endmodule

// File: verification/psif_ecu_rx.sv
// Receiving controller model that decodes phase III status messages.
`timescale 1ns/1ns
module psif_ecu_rx
    import psif_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_vld,
    input wire psif_frame_t i_frame,
    output logic [7:0] o_ready_cnt,
    output logic [7:0] o_defect_cnt
);
    // The receiver only listens and never stalls the sensor, so it has no slow mode.
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_ready_cnt <= 8'h00;
            o_defect_cnt <= 8'h00;
        end else if (i_vld && i_frame.kind == FK_PH3) begin
            if (i_frame.payload[15:6] == MSG_READY) begin
                o_ready_cnt <= o_ready_cnt + 8'h01;
            end
            if (i_frame.payload[15:6] == MSG_DEFECT) begin
                o_defect_cnt <= o_defect_cnt + 8'h01;
            end
        end
    end
endmodule

// File: verification/tb_top.sv
// Self-checking testbench of the PSI5 initialization and error frame generator.
`timescale 1ns/1ns
module tb_top;
    import psif_pkg::*;
    localparam logic [15:0] MID_TAB = 16'hD8E4;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [3:0] addr = 4'h0;
    logic [15:0] wdata = 16'h0000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [15:0] rdata;
    logic init_start = 1'b0;
    logic frame_req = 1'b0;
    logic err_rep = 1'b0;
    psif_diag_t diag = 6'h00;
    logic [23:0] app_data = 24'h000000;
    logic frame_vld;
    psif_frame_t frame;
    psif_frame_t fr;
    logic [15:0] rv;
    logic [15:0] idw [8];
    logic [23:0] e;
    logic [7:0] ready_cnt;
    logic [7:0] defect_cnt;
    int errors = 0;
    int checked = 0;
    int cyc = 0;
    int p;

    always #5 clk = ~clk;

    psif_framer u_dut (.I_CORE_CLK(clk), .I_RST(rst), .I_ADDR(addr), .I_WDATA(wdata),
        .I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .I_INIT_START(init_start),
        .I_FRAME_REQ(frame_req), .I_ERROR_REPORT(err_rep), .I_DIAG(diag),
        .I_APP_DATA(app_data), .O_FRAME_VLD(frame_vld), .O_FRAME(frame));

    psif_ecu_rx u_ecu (.i_clk(clk), .i_rst(rst), .i_vld(frame_vld), .i_frame(frame),
        .o_ready_cnt(ready_cnt), .o_defect_cnt(defect_cnt));

    task automatic complete_run();
        $display("errors %0d checked %0d", errors, checked);
        if (errors == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [23:0] seen, input logic [23:0] exp);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe, so sample just past that edge.
    task automatic rd_reg(input logic [3:0] a);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        rv = rdata;
    endtask

    task automatic req(input logic exp_vld);
        @(posedge clk);
        frame_req <= 1'b1;
        @(posedge clk);
        frame_req <= 1'b0;
        #1;
        chk("frame valid", 24'(frame_vld), 24'(exp_vld));
        fr = frame;
    endtask

    task automatic start(input logic [1:0] seq, input logic [1:0] k, input logic [6:0] rep,
                         input logic lowsel);
        wr_reg(ADDR_CFG_OUTPUT, {10'h000, k, PSIZE_F16});
        wr_reg(ADDR_CFG_PROTOCOL, {rep, 4'h0, seq, 3'h0});
        wr_reg(ADDR_CFG_PROTOCOL2, {15'h0000, lowsel});
        @(posedge clk);
        init_start <= 1'b1;
        @(posedge clk);
        init_start <= 1'b0;
    endtask

    function automatic logic [3:0] exp_nib(input int i);
        int w;
        int n;
        w = 7 - i / 4;
        n = 3 - i % 4;
        if (i >= 4 && i < 12) begin
            w = (i < 8) ? 6 : 5;
            n = int'(MID_TAB[(11 - i) * 2 +: 2]);
        end
        return idw[w][n * 4 +: 4];
    endfunction

    task automatic run_ph2(input int k);
        for (int i = 0; i < 32; i++) begin
            for (int r = 0; r <= k; r++) begin
                req(1'b1);
                chk("nibble", 24'(fr.payload[3:0]), 24'(exp_nib(i)));
                chk("nibble id", 24'(fr.nibble_id), 24'(i));
                chk("ph2 status", 24'(fr.status_flag), 24'h0);
                chk("ph2 kind", 24'(fr.kind), 24'(FK_PH2));
            end
        end
    endtask

    // The second half of the repeats report a defect, so both messages show up in one run.
    task automatic run_ph3(input int n, input logic lowsel, input logic [5:0] pat);
        for (int j = 0; j < n; j++) begin
            @(posedge clk);
            diag <= (j >= n / 2) ? pat : 6'h00;
            req(1'b1);
            if (j >= n / 2) begin
                e = {8'h00, MSG_DEFECT, lowsel ? pat : 6'h00};
            end else begin
                e = {8'h00, MSG_READY, lowsel ? 6'h00 : 6'h01};
            end
            chk("ph3 kind", 24'(fr.kind), 24'(FK_PH3));
            chk("ph3 payload", fr.payload, e);
            chk("ph3 status", 24'(fr.status_flag), 24'(j >= n / 2));
        end
        @(posedge clk);
        diag <= 6'h00;
        req(1'b1);
        chk("after ph3 kind", 24'(fr.kind), 24'(FK_APP));
    endtask

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            errors++;
            complete_run();
        end
    end

    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        rd_reg(ADDR_CFG_OUTPUT);
        chk("cfg output reset", 24'(rv), 24'h000001);
        rd_reg(ADDR_CFG_PROTOCOL);
        chk("cfg protocol reset", 24'(rv), 24'h000000);
        rd_reg(ADDR_SEQ_STATUS);
        chk("status reset", 24'(rv), 24'h001000);
        req(1'b0);
        for (int j = 0; j < 8; j++) begin
            idw[j] = 16'h1234 + 16'(j) * 16'h1111;
            wr_reg(4'(j), idw[j]);
        end
        wr_reg(4'hC, 16'hFFFF);
        for (int j = 0; j < 8; j++) begin
            rd_reg(4'(j));
            chk("ident word", 24'(rv), 24'(idw[j]));
        end
        rd_reg(4'hC);
        chk("unmapped read", 24'(rv), 24'h000000);
        start(SEQ_AFTER_PH3, 2'h1, 7'h01, 1'b0);
        run_ph2(1);
        run_ph3(4, 1'b0, 6'h2D);
        rd_reg(ADDR_SEQ_STATUS);
        chk("state app", 24'(rv[15:12]), 24'h000008);
        @(posedge clk);
        err_rep <= 1'b1;
        for (int f = 1; f < 16; f++) begin
            wr_reg(ADDR_CFG_OUTPUT, 16'(f));
            diag <= (f % 2 == 1) ? 6'h2D : 6'h33;
            req(1'b1);
            p = f + 9;
            e = 24'h0001F4;
            if (p >= 16) begin
                e = (e << (p - 10)) | (24'(diag) << (p - 16));
            end else if (p > 10) begin
                e = (e << (p - 10)) | (24'(diag) >> (16 - p));
            end
            chk("err payload", fr.payload, e);
            chk("err kind", 24'(fr.kind), 24'(FK_ERR));
            chk("parity select", 24'(fr.parity_sel), 24'(p <= 10));
            if (p > 10) chk("err status", 24'(fr.status_flag), 24'h000001);
        end
        @(posedge clk);
        err_rep <= 1'b0;
        diag <= 6'h00;
        app_data <= 24'hA5C33C;
        req(1'b1);
        chk("app kind", 24'(fr.kind), 24'(FK_APP));
        chk("app payload", fr.payload, 24'hA5C33C);
        start(SEQ_AFTER_PH3, 2'h0, 7'h00, 1'b1);
        run_ph2(0);
        run_ph3(2, 1'b1, 6'h15);
        for (int c = 0; c < 4; c++) begin
            if (c == 2) continue;
            start(2'(c), 2'h0, 7'h00, 1'b0);
            if (c == 1) run_ph2(0);
            req(1'b1);
            chk("seq kind", 24'(fr.kind), 24'(FK_APP));
        end
        chk("ready count", 24'(ready_cnt), 24'h000003);
        chk("defect count", 24'(defect_cnt), 24'h000003);
        complete_run();
    end
endmodule
